//--- rtl/gpr_consts.vh
`ifndef GPR_CONSTS_VH
`define GPR_CONSTS_VH

// Byte addresses of the pin register pairs (low byte; high byte is +1)
`define GPR_ADDR_PIN_EVT_LO 8'h0a
`define GPR_ADDR_PIN_EVT_HI 8'h0b
`define GPR_ADDR_DIR_LO 8'h10
`define GPR_ADDR_DIR_HI 8'h11
`define GPR_ADDR_MON_LO 8'h12
`define GPR_ADDR_MON_HI 8'h13
`define GPR_ADDR_OUT_LO 8'h14
`define GPR_ADDR_OUT_HI 8'h15
`define GPR_ADDR_FUNC_LO 8'h16
`define GPR_ADDR_FUNC_HI 8'h17
// Routing registers, one per pin at base plus pin number
`define GPR_ADDR_ROUTE_BASE 8'h20
`define GPR_ADDR_ROUTE_MASK 8'hf0

// Routing register fields
`define GPR_ROUTE_EN_BIT 7
`define GPR_ROUTE_IDLE_BIT 3
`define GPR_ROUTE_SEL_MSB 2
`define GPR_ROUTE_SEL_LSB 0

// Reset values
`define GPR_RST_PIN16 16'h0000
`define GPR_RST_ROUTE 8'h00

// PWM base clock: rates in kHz, fractional divider from the system clock
`define GPR_CLK_KHZ 40000
`define GPR_PWM_BASE_KHZ 512
`define GPR_PWM_OUT_KHZ 32
`define GPR_PWM_STEPS (`GPR_PWM_BASE_KHZ / `GPR_PWM_OUT_KHZ)

`endif

//--- rtl/gpr_pwm_unit.v
`timescale 1ns/1ps
`include "gpr_consts.vh"

module gpr_pwm_unit #(
  parameter LEN_W = 8
) (
  input wire clock,
  input wire rst,
  input wire base_tick,
  input wire [3:0] duty,
  input wire [LEN_W-1:0] seq_len,
  input wire host_start,
  input wire host_stop,
  input wire touch_mode,
  input wire touch_trig,
  output reg wave,
  output reg running,
  output reg done
);

  reg [3:0] phase_q;
  reg [LEN_W-1:0] count_q;
  wire start_req;
  wire period_end;

  // Touch mode takes the trigger from the sense input instead of the host
  assign start_req = touch_mode ? touch_trig : host_start;
  assign period_end = base_tick && (phase_q == 4'hf);

  // Sixteen base ticks make one output period: 512 kHz / 16 = 32 kHz
  always @(posedge clock) begin
    if (rst) begin
      phase_q <= 4'h0;
      count_q <= {LEN_W{1'b0}};
      running <= 1'b0;
      done <= 1'b0;
      wave <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start_req && !running) begin
        running <= 1'b1;
        phase_q <= 4'h0;
        count_q <= {LEN_W{1'b0}};
      end else if (host_stop) begin
        running <= 1'b0;
      end else if (running && base_tick) begin
        phase_q <= phase_q + 4'h1;
        if (period_end) begin
          count_q <= count_q + {{(LEN_W-1){1'b0}}, 1'b1};
          // Zero length runs forever; otherwise end after seq_len periods
          if (seq_len != {LEN_W{1'b0}} && count_q + {{(LEN_W-1){1'b0}}, 1'b1} == seq_len) begin
            running <= 1'b0;
            done <= 1'b1;
          end
        end
      end
      // Duty code n gives (n+1)/16 high time, code 15 is full on
      wave <= running && (phase_q <= duty);
    end
  end

endmodule

//--- rtl/gpr_gpio_port.v
`timescale 1ns/1ps
`include "gpr_consts.vh"

module gpr_gpio_port #(
  parameter NPIN = 16,
  parameter NPWM = 8,
  parameter LEN_W = 8
) (
  input wire clock,
  input wire rst,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire [NPIN-1:0] pin_i,
  output reg [NPIN-1:0] pin_o,
  output reg [NPIN-1:0] pin_oe,
  output wire [NPIN-1:0] cap_sense_sel,
  output wire pin_event_pend,
  input wire [NPWM*4-1:0] pwm_duty,
  input wire [NPWM*LEN_W-1:0] pwm_seq_len,
  input wire [NPWM-1:0] pwm_start,
  input wire [NPWM-1:0] pwm_stop,
  input wire [NPWM-1:0] pwm_touch_mode,
  input wire [NPWM-1:0] touch_trig,
  output wire [NPWM-1:0] pwm_running,
  output wire [NPWM-1:0] pwm_done
);

  localparam [15:0] CLK_KHZ = `GPR_CLK_KHZ;
  localparam [15:0] BASE_KHZ = `GPR_PWM_BASE_KHZ;

  reg [NPIN-1:0] dir_q;
  reg [NPIN-1:0] out_q;
  reg [NPIN-1:0] func_q;
  reg [NPIN-1:0] evt_q;
  reg [NPIN-1:0] evt_d;
  reg [NPIN-1:0] mon_q;
  reg [NPIN-1:0] prev_q;
  reg prev_ok_q;
  reg mon_ok_q;
  reg [7:0] route_q [0:NPIN-1];
  reg [15:0] acc_q;
  reg base_tick_q;
  reg [NPIN-1:0] lo_mask;
  reg [NPIN-1:0] hi_mask;
  reg [NPIN-1:0] wr_bits;
  reg [7:0] rd_d;
  wire [NPWM-1:0] pwm_wave;
  wire route_hit;
  wire [3:0] route_idx;
  wire [NPIN-1:0] is_input;
  integer i;

  assign route_hit = (reg_addr & `GPR_ADDR_ROUTE_MASK) == `GPR_ADDR_ROUTE_BASE;
  assign route_idx = reg_addr[3:0];
  assign cap_sense_sel = ~func_q;
  assign pin_event_pend = |evt_q;

  // Fractional divider: 512 enables every 40000 kHz worth of clocks, exact on average
  always @(posedge clock) begin
    if (rst) begin
      acc_q <= 16'h0000;
      base_tick_q <= 1'b0;
    end else if (acc_q + BASE_KHZ >= CLK_KHZ) begin
      acc_q <= acc_q + BASE_KHZ - CLK_KHZ;
      base_tick_q <= 1'b1;
    end else begin
      acc_q <= acc_q + BASE_KHZ;
      base_tick_q <= 1'b0;
    end
  end

  // Eight controllers, all sharing the one base tick
  genvar g;
  generate
    for (g = 0; g < NPWM; g = g + 1) begin : gen_pwm
      gpr_pwm_unit #(.LEN_W(LEN_W)) u_pwm (
        .clock(clock),
        .rst(rst),
        .base_tick(base_tick_q),
        .duty(pwm_duty[g*4 +: 4]),
        .seq_len(pwm_seq_len[g*LEN_W +: LEN_W]),
        .host_start(pwm_start[g]),
        .host_stop(pwm_stop[g]),
        .touch_mode(pwm_touch_mode[g]),
        .touch_trig(touch_trig[g]),
        .wave(pwm_wave[g]),
        .running(pwm_running[g]),
        .done(pwm_done[g])
      );
    end
  endgenerate

  // Per-pin input qualification for change events
  genvar p;
  generate
    for (p = 0; p < NPIN; p = p + 1) begin : gen_in
      assign is_input[p] = !dir_q[p] && !route_q[p][`GPR_ROUTE_EN_BIT];
    end
  endgenerate

  // Byte lane masks for the split 16-bit pin registers
  always @* begin
    lo_mask = {{(NPIN-8){1'b0}}, 8'hff};
    hi_mask = ~lo_mask;
    wr_bits = {reg_wdata, reg_wdata};
  end

  // Pin-wide registers: each byte address writes only its own eight pins
  always @(posedge clock) begin
    if (rst) begin
      dir_q <= `GPR_RST_PIN16;
      out_q <= `GPR_RST_PIN16;
      func_q <= `GPR_RST_PIN16;
      for (i = 0; i < NPIN; i = i + 1) begin
        route_q[i] <= `GPR_RST_ROUTE;
      end
    end else if (reg_wr) begin
      case (reg_addr)
        `GPR_ADDR_DIR_LO: dir_q <= (dir_q & hi_mask) | (wr_bits & lo_mask);
        `GPR_ADDR_DIR_HI: dir_q <= (dir_q & lo_mask) | (wr_bits & hi_mask);
        `GPR_ADDR_OUT_LO: out_q <= (out_q & hi_mask) | (wr_bits & lo_mask);
        `GPR_ADDR_OUT_HI: out_q <= (out_q & lo_mask) | (wr_bits & hi_mask);
        `GPR_ADDR_FUNC_LO: func_q <= (func_q & hi_mask) | (wr_bits & lo_mask);
        `GPR_ADDR_FUNC_HI: func_q <= (func_q & lo_mask) | (wr_bits & hi_mask);
        default: begin
          // Reserved bits 6:4 are not stored and read back as zero
          if (route_hit) begin
            route_q[route_idx] <= reg_wdata & 8'h8f;
          end
        end
      endcase
    end
  end

  // Pin sampling and change detection; arm only once both stages hold real samples,
  // otherwise a pin that is high at release would raise a false event
  always @(posedge clock) begin
    if (rst) begin
      mon_q <= `GPR_RST_PIN16;
      prev_q <= `GPR_RST_PIN16;
      mon_ok_q <= 1'b0;
      prev_ok_q <= 1'b0;
    end else begin
      mon_q <= pin_i;
      prev_q <= mon_q;
      mon_ok_q <= 1'b1;
      prev_ok_q <= mon_ok_q;
    end
  end

  // Event flags: write one clears, but a new change in the same cycle wins
  always @* begin
    evt_d = evt_q;
    if (reg_wr && reg_addr == `GPR_ADDR_PIN_EVT_LO) begin
      evt_d = evt_d & ~(wr_bits & lo_mask);
    end
    if (reg_wr && reg_addr == `GPR_ADDR_PIN_EVT_HI) begin
      evt_d = evt_d & ~(wr_bits & hi_mask);
    end
    if (prev_ok_q) begin
      evt_d = evt_d | ((mon_q ^ prev_q) & is_input);
    end
  end

  always @(posedge clock) begin
    if (rst) begin
      evt_q <= `GPR_RST_PIN16;
    end else begin
      evt_q <= evt_d;
    end
  end

  // Read mux; unmapped addresses read zero
  always @* begin
    rd_d = 8'h00;
    case (reg_addr)
      `GPR_ADDR_PIN_EVT_LO: rd_d = evt_q[7:0];
      `GPR_ADDR_PIN_EVT_HI: rd_d = evt_q[15:8];
      `GPR_ADDR_DIR_LO: rd_d = dir_q[7:0];
      `GPR_ADDR_DIR_HI: rd_d = dir_q[15:8];
      `GPR_ADDR_MON_LO: rd_d = mon_q[7:0];
      `GPR_ADDR_MON_HI: rd_d = mon_q[15:8];
      `GPR_ADDR_OUT_LO: rd_d = out_q[7:0];
      `GPR_ADDR_OUT_HI: rd_d = out_q[15:8];
      `GPR_ADDR_FUNC_LO: rd_d = func_q[7:0];
      `GPR_ADDR_FUNC_HI: rd_d = func_q[15:8];
      default: begin
        if (route_hit) begin
          rd_d = route_q[route_idx];
        end
      end
    endcase
  end

  always @(posedge clock) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rd_d;
    end
  end

  // Pin drivers; each pin picks its controller independently, so sharing is free
  always @(posedge clock) begin
    if (rst) begin
      pin_o <= `GPR_RST_PIN16;
      pin_oe <= `GPR_RST_PIN16;
    end else begin
      for (i = 0; i < NPIN; i = i + 1) begin
        if (!func_q[i]) begin
          // Capacitive-sense role: the digital driver stays off
          pin_oe[i] <= 1'b0;
          pin_o[i] <= 1'b0;
        end else if (route_q[i][`GPR_ROUTE_EN_BIT]) begin
          pin_oe[i] <= 1'b1;
          if (pwm_running[route_q[i][`GPR_ROUTE_SEL_MSB:`GPR_ROUTE_SEL_LSB]]) begin
            pin_o[i] <= pwm_wave[route_q[i][`GPR_ROUTE_SEL_MSB:`GPR_ROUTE_SEL_LSB]];
          end else begin
            pin_o[i] <= route_q[i][`GPR_ROUTE_IDLE_BIT];
          end
        end else begin
          pin_oe[i] <= dir_q[i];
          pin_o[i] <= out_q[i];
        end
      end
    end
  end

endmodule

//--- testbench/gpr_pad_model.sv
`timescale 1ns/1ps
// Pad ring: a driving port wins, else the outside signal sets the level
module gpr_pad_model (
  input wire [15:0] pin_o,
  input wire [15:0] pin_oe,
  input wire [15:0] ext_lvl,
  output wire [15:0] pin_i
);
  // Outside sources never float here, so no unknown reaches the pad
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext_lvl);
endmodule

//--- testbench/gpr_gpio_port_sva.sv
`timescale 1ns/1ps
module gpr_gpio_port_sva #(
  parameter NPIN = 16,
  parameter NPWM = 8
) (
  input logic clock,
  input logic rst,
  input logic [7:0] reg_addr,
  input logic reg_rd,
  input logic [7:0] reg_rdata,
  input logic [NPIN-1:0] pin_i,
  input logic [NPIN-1:0] pin_o,
  input logic [NPIN-1:0] pin_oe,
  input logic [NPIN-1:0] cap_sense_sel,
  input logic pin_event_pend,
  input logic [NPWM-1:0] pwm_start,
  input logic [NPWM-1:0] pwm_stop,
  input logic [NPWM-1:0] pwm_touch_mode,
  input logic [NPWM-1:0] touch_trig,
  input logic [NPWM-1:0] pwm_running,
  input logic [NPWM-1:0] pwm_done
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // Reset leaves every pin an undriven sense input
  property p_rst_vals; $past(rst) |-> !pin_oe && !pin_o && !reg_rdata && &cap_sense_sel; endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("reset state wrong");
  // Sense-role pins must never drive, a cycle of lag allowed
  property p_sense_quiet; (pin_oe & $past(cap_sense_sel)) == 0; endproperty
  a_sense_quiet: assert property (p_sense_quiet) else $error("sense pin driven");
  // Stable pins read back as sampled; reset edge excluded, monitor was held
  property p_mon_read;
    reg_rd && reg_addr == 8'h12 && !$past(rst) && $stable(pin_i) |=> reg_rdata == $past(pin_i[7:0]);
  endproperty
  a_mon_read: assert property (p_mon_read) else $error("pin state read wrong");
  property p_evt_cause; $rose(pin_event_pend) |-> $past(pin_i, 1) != $past(pin_i, 5); endproperty
  a_evt_cause: assert property (p_evt_cause) else $error("event without pin change");
  // Sequence end coincides with running dropping, and lasts one cycle
  property p_done_drop; (pwm_done & (pwm_running | ~$past(pwm_running))) == 0; endproperty
  a_done_drop: assert property (p_done_drop) else $error("done without stop");
  property p_done_pulse; (pwm_done & $past(pwm_done)) == 0; endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done too long");
  property p_host_start; &(pwm_running | ~$past(pwm_start & ~pwm_touch_mode & ~pwm_running)); endproperty
  a_host_start: assert property (p_host_start) else $error("host start lost");
  property p_touch_start; &(pwm_running | ~$past(touch_trig & pwm_touch_mode & ~pwm_running)); endproperty
  a_touch_start: assert property (p_touch_start) else $error("touch start lost");
  property p_stop; (pwm_running & $past(pwm_stop & pwm_running)) == 0; endproperty
  a_stop: assert property (p_stop) else $error("stop ignored");
  c_event: cover property ($rose(pin_event_pend));
  c_done: cover property (|pwm_done);
  c_touch: cover property (|(pwm_running & pwm_touch_mode));
endmodule

bind gpr_gpio_port gpr_gpio_port_sva #(.NPIN(NPIN), .NPWM(NPWM)) gpr_gpio_port_sva_inst (
  .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe), .cap_sense_sel(cap_sense_sel),
  .pin_event_pend(pin_event_pend), .pwm_start(pwm_start), .pwm_stop(pwm_stop),
  .pwm_touch_mode(pwm_touch_mode), .touch_trig(touch_trig), .pwm_running(pwm_running),
  .pwm_done(pwm_done));

//--- testbench/gpr_gpio_port_tb.sv
`timescale 1ns/1ps
module gpr_gpio_port_tb;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic [15:0] pin_i, pin_o, pin_oe, cap_sense_sel;
  logic [15:0] ext_lvl = 16'h0000;
  logic pin_event_pend;
  logic [31:0] pwm_duty = 32'h77777777;
  logic [63:0] pwm_seq_len = {8{8'h01}};
  logic [7:0] pwm_start = 8'h00;
  logic [7:0] pwm_stop = 8'h00;
  logic [7:0] pwm_touch_mode = 8'h00;
  logic [7:0] touch_trig = 8'h00;
  logic [7:0] pwm_running, pwm_done;
  int err_total = 0;
  int total_checks = 0;
  int hi, n;

  always #12.5 clock = ~clock;

  gpr_gpio_port gpr_gpio_port_inst (.clock(clock), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe), .cap_sense_sel(cap_sense_sel),
    .pin_event_pend(pin_event_pend), .pwm_duty(pwm_duty), .pwm_seq_len(pwm_seq_len),
    .pwm_start(pwm_start), .pwm_stop(pwm_stop), .pwm_touch_mode(pwm_touch_mode),
    .touch_trig(touch_trig), .pwm_running(pwm_running), .pwm_done(pwm_done));
  gpr_pad_model gpr_pad_model_inst (.pin_o(pin_o), .pin_oe(pin_oe), .ext_lvl(ext_lvl),
    .pin_i(pin_i));

  // Bus and compare helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 chk({8'h00, reg_rdata}, {8'h00, exp});
  endtask
  // Ends just past an edge so outputs have settled
  task automatic tick(input int c);
    repeat (c) @(posedge clock);
    #1;
  endtask
  task automatic end_sim;
    $display("checks %0d, mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Watchdog: the sequence needs about 1500 cycles
  initial begin
    repeat (20000) @(posedge clock);
    err_total++;
    end_sim();
  end

  // Main sequence
  initial begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    tick(4);
    for (n = 16; n < 24; n++) rd(n[7:0], 8'h00);
    for (n = 0; n < 16; n++) rd(8'h20 + n[7:0], 8'h00);
    chk(cap_sense_sel, 16'hffff);
    rd(8'h40, 8'h00);
    wr(8'h16, 8'hff);
    wr(8'h17, 8'hff);
    wr(8'h10, 8'h0f);
    wr(8'h14, 8'ha5);
    wr(8'h15, 8'h5a);
    wr(8'h12, 8'hff);
    ext_lvl <= 16'h3c00;
    tick(4);
    rd(8'h10, 8'h0f);
    rd(8'h11, 8'h00);
    rd(8'h15, 8'h5a);
    rd(8'h17, 8'hff);
    chk(cap_sense_sel, 16'h0000);
    chk(pin_oe, 16'h000f);
    chk(pin_o & pin_oe, 16'h0005);
    rd(8'h12, 8'h05);
    rd(8'h13, 8'h3c);
    // Only the four input pins that moved raise a flag
    rd(8'h0a, 8'h00);
    rd(8'h0b, 8'h3c);
    wr(8'h0b, 8'h0c);
    rd(8'h0b, 8'h30);
    wr(8'h0b, 8'h30);
    tick(1);
    chk({15'h0000, pin_event_pend}, 16'h0000);
    // Every pin onto controller 2, idle level high on odd pins, reserved bits dropped
    for (n = 0; n < 16; n++) wr(8'h20 + n[7:0], {4'hf, n[0], 3'h2});
    for (n = 0; n < 16; n++) rd(8'h20 + n[7:0], {4'h8, n[0], 3'h2});
    tick(2);
    chk(pin_oe, 16'hffff);
    chk(pin_o, 16'haaaa);
    @(posedge clock);
    pwm_start <= 8'h04;
    @(posedge clock);
    pwm_start <= 8'h00;
    hi = 0;
    for (n = 0; n < 2000 && !pwm_done[2]; n++) begin
      tick(1);
      hi += pin_o[0];
      if (pin_o !== {16{pin_o[0]}}) chk(pin_o, {16{pin_o[0]}});
    end
    // One 32 kHz period is 1250 clocks, half of it high at duty code 7
    chk(16'(n > 1160 && n < 1340), 16'h0001);
    chk(16'(hi > 540 && hi < 710), 16'h0001);
    tick(2);
    chk(pin_o, 16'haaaa);
    // Controller 5 in touch mode ignores host start
    @(posedge clock);
    pwm_touch_mode <= 8'h20;
    pwm_start <= 8'h20;
    @(posedge clock);
    pwm_start <= 8'h00;
    tick(2);
    chk({8'h00, pwm_running}, 16'h0000);
    @(posedge clock);
    touch_trig <= 8'h20;
    @(posedge clock);
    touch_trig <= 8'h00;
    tick(1);
    chk({8'h00, pwm_running}, 16'h0020);
    @(posedge clock);
    pwm_stop <= 8'h20;
    @(posedge clock);
    pwm_stop <= 8'h00;
    tick(1);
    chk({8'h00, pwm_running}, 16'h0000);
    wr(8'h25, 8'h00);
    tick(2);
    chk(pin_oe, 16'hffdf);
    // Host parks the freed pin as an output so it does not float
    wr(8'h10, 8'h2f);
    tick(2);
    chk(pin_oe, 16'hffff);
    chk(pin_o, 16'haaaa);
    end_sim();
  end
endmodule
